// File: design/fault_sup_pkg.sv
// Purpose: shared constants and carriers for the start fault supervisor
// Assumes: 25 MHz sys_clk, 1 ms supervision tick
// Notes:   all thresholds counted in ticks
package fault_sup_pkg;

    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TICK_US         = 1000;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned IGNORE_MS       = 100;
    localparam int unsigned TRIP_MS         = 2000;
    localparam int unsigned LINK_MS         = 15000;
    localparam int unsigned BYPASS_RAMP_MS  = 6000;
    localparam int unsigned IGNORE_TICKS    = IGNORE_MS * 1000 / TICK_US;
    localparam int unsigned TRIP_TICKS      = TRIP_MS * 1000 / TICK_US;
    localparam int unsigned LINK_TICKS      = LINK_MS * 1000 / TICK_US;
    localparam int unsigned RAMP6_TICKS     = BYPASS_RAMP_MS * 1000 / TICK_US;
    localparam int unsigned TW              = 16;

    // Reaction to a silent serial link
    typedef enum logic [1:0] {
        LINK_IGNORE     = 2'h0,
        LINK_STOP_ALARM = 2'h1,
        LINK_RUN_ALARM  = 2'h2
    } link_react_t;

    // Mains and motor state inputs
    typedef struct packed {
        logic multi_loss;
        logic single_loss;
        logic accelerating;
        logic full_voltage;
        logic current_limiting;
        logic ramp_elapsed;
        logic cl_mode;
    } plant_t;

    // Operator and serial master inputs
    typedef struct packed {
        logic start_cmd;
        logic stop_cmd;
        logic reset_key;
        logic serial_mode;
        logic link_activity;
    } oper_t;

    // Motor control outputs
    typedef struct packed {
        logic run;
        logic soft_restart;
        logic freewheel_stop;
        logic limit_release;
        logic full_ramp_6s;
    } motor_t;

endpackage

// File: design/motor_start_fault_supervisor.sv
// Purpose: phase, current limit and serial link fault supervision
// Assumes: plant and oper inputs are asynchronous levels; link_activity pulses stretched
// Notes:   outputs registered; category 2 trips self-clear on next start
module motor_start_fault_supervisor
    import fault_sup_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    // Plant and operator
    input  wire fault_sup_pkg::plant_t     plant,
    input  wire fault_sup_pkg::oper_t      oper,
    // Configuration
    input  wire logic                      single_phase_run,
    input  wire logic                      continue_on_timeout,
    input  wire fault_sup_pkg::link_react_t link_react,
    // Motor control
    output fault_sup_pkg::motor_t          motor,
    // Alarms
    output logic                           phase_input_alarm,
    output logic                           current_limit_timeout_alarm,
    output logic                           serial_link_alarm
);
    import fault_sup_pkg::*;

    // Divider is 16 bits wide
    if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_tick_div_check
        $error("TICK_DIV out of range");
    end

    // Three-stage input synchronisers; change accepted when stages 2 and 3 agree
    localparam int NIN = $bits(plant_t) + $bits(oper_t);
    logic [NIN-1:0] s1_q, s2_q, s3_q, filt_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            filt_q <= '0;
        end else begin
            s1_q <= {plant, oper};
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < NIN; i++) begin
                if (s2_q[i] == s3_q[i]) filt_q[i] <= s3_q[i];
            end
        end
    end
    plant_t pl;
    oper_t  op;
    assign {pl, op} = filt_q;

    // Common tick
    logic [15:0] div_q;
    logic        tick;
    always_ff @(posedge sys_clk) begin
        if (reset || div_q == 16'(TICK_DIV - 1)) div_q <= 16'h0000;
        else div_q <= div_q + 16'h0001;
    end
    assign tick = (div_q == 16'(TICK_DIV - 1));

    // Phase failure classification
    logic running_q;
    logic loss_as_multi, loss_single_run, fail_now;
    assign loss_as_multi   = pl.multi_loss || (pl.single_loss && pl.accelerating);
    assign loss_single_run = pl.single_loss && pl.full_voltage && !pl.accelerating;
    assign fail_now        = loss_as_multi || (loss_single_run && !single_phase_run);

    // Failure duration timer, restarts when mains is healthy again
    logic [TW-1:0] fail_cnt_q;
    always_ff @(posedge sys_clk) begin
        if (reset || !(fail_now || loss_single_run)) fail_cnt_q <= '0;
        else if (tick && fail_cnt_q != TW'(TRIP_TICKS)) fail_cnt_q <= fail_cnt_q + 1'b1;
    end
    logic past_ignore, past_trip;
    assign past_ignore = fail_cnt_q >= TW'(IGNORE_TICKS);
    assign past_trip   = fail_cnt_q == TW'(TRIP_TICKS);

    // Pause pending a soft restart while loss is in the 100 ms - 2 s window
    logic pause_q;
    always_ff @(posedge sys_clk) begin
        if (reset) pause_q <= 1'b0;
        else if (fail_now && loss_as_multi && past_ignore && !past_trip && running_q)
            pause_q <= 1'b1;
        else if (past_trip || !running_q) pause_q <= 1'b0;
        else if (!fail_now) pause_q <= 1'b0;
    end
    logic restart_d;
    assign restart_d = pause_q && !fail_now && running_q;

    // Phase input alarm
    logic phase_trip, phase_alarm_q;
    assign phase_trip = past_trip && fail_now && running_q;
    always_ff @(posedge sys_clk) begin
        if (reset) phase_alarm_q <= 1'b0;
        else if (past_trip && running_q) phase_alarm_q <= 1'b1;
        // With single_phase_run set, phase return clears even after a stop, the alarm is only a report here
        else if (single_phase_run && !pl.single_loss && !pl.multi_loss)
            phase_alarm_q <= 1'b0;
        else if (op.start_cmd) phase_alarm_q <= 1'b0;
    end

    // Current-limit time-out
    logic cl_alarm_q, cl_trip, bypass_q;
    logic [TW-1:0] ramp_cnt_q;
    logic cl_fire;
    assign cl_fire = pl.cl_mode && pl.current_limiting && pl.ramp_elapsed && running_q
                     && !cl_alarm_q;
    assign cl_trip = cl_fire && !continue_on_timeout;
    always_ff @(posedge sys_clk) begin
        if (reset) cl_alarm_q <= 1'b0;
        else if (cl_fire) cl_alarm_q <= 1'b1;
        else if (op.reset_key || op.stop_cmd || op.start_cmd) cl_alarm_q <= 1'b0;
    end
    always_ff @(posedge sys_clk) begin
        if (reset) bypass_q <= 1'b0;
        else if (cl_fire && continue_on_timeout) bypass_q <= 1'b1;
        else if (!running_q || ramp_cnt_q == TW'(RAMP6_TICKS)) bypass_q <= 1'b0;
    end
    always_ff @(posedge sys_clk) begin
        if (reset || !bypass_q) ramp_cnt_q <= '0;
        else if (tick) ramp_cnt_q <= ramp_cnt_q + 1'b1;
    end

    // Serial link silence
    logic          link_active;
    logic [TW-1:0] link_cnt_q;
    logic          link_alarm_q, link_broken, link_stop;
    assign link_active = op.serial_mode && link_react != LINK_IGNORE;
    always_ff @(posedge sys_clk) begin
        if (reset || !op.serial_mode || op.link_activity) link_cnt_q <= '0;
        else if (tick && link_cnt_q != TW'(LINK_TICKS)) link_cnt_q <= link_cnt_q + 1'b1;
    end
    // Single pulse on reaching the limit, so a keypad clear is not undone
    assign link_broken = tick && link_cnt_q == TW'(LINK_TICKS - 1) && link_active;
    assign link_stop   = link_broken && link_react == LINK_STOP_ALARM;
    always_ff @(posedge sys_clk) begin
        if (reset) link_alarm_q <= 1'b0;
        else if (op.link_activity || op.reset_key) link_alarm_q <= 1'b0;
        else if (link_broken) link_alarm_q <= 1'b1;
    end

    // Run state: category 2 stops allow a plain restart
    logic two_phase;
    assign two_phase = single_phase_run && loss_single_run;
    always_ff @(posedge sys_clk) begin
        if (reset) running_q <= 1'b0;
        else if (op.stop_cmd || phase_trip || cl_trip || link_stop) running_q <= 1'b0;
        else if (op.start_cmd) running_q <= 1'b1;
    end

    // Registered outputs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            motor <= '0;
        end else begin
            motor.run            <= running_q && !pause_q && !op.stop_cmd;
            motor.soft_restart   <= restart_d;
            motor.freewheel_stop <= two_phase && running_q && op.stop_cmd;
            motor.limit_release  <= bypass_q;
            motor.full_ramp_6s   <= bypass_q;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phase_input_alarm           <= 1'b0;
            current_limit_timeout_alarm <= 1'b0;
            serial_link_alarm           <= 1'b0;
        end else begin
            phase_input_alarm           <= phase_alarm_q;
            current_limit_timeout_alarm <= cl_alarm_q;
            serial_link_alarm           <= link_alarm_q;
        end
    end

endmodule

// File: verif/fault_sup_props.sv
// Purpose: port checks for the fault supervisor
// Assumes: TICK_DIV handed on by the bind
// Notes:   one tick of slack, input sync only adds
module fault_sup_props
    import fault_sup_pkg::*;
#(
    parameter int unsigned TICK_DIV = 2
) (
    input wire logic sys_clk, reset, single_phase_run, continue_on_timeout,
    input wire fault_sup_pkg::plant_t plant,
    input wire fault_sup_pkg::oper_t oper,
    input wire fault_sup_pkg::link_react_t link_react,
    input wire fault_sup_pkg::motor_t motor,
    input wire logic phase_input_alarm, current_limit_timeout_alarm, serial_link_alarm
);
    int unsigned loss_n = 0;
    int unsigned quiet_n = 0;
    always_ff @(posedge sys_clk) begin
        loss_n  <= (plant.multi_loss | plant.single_loss) ? loss_n + 1 : 0;
        quiet_n <= (oper.serial_mode & !oper.link_activity) ? quiet_n + 1 : 0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_short_ignored: assert property ($fell(motor.run) && plant.multi_loss
        |-> loss_n >= (IGNORE_TICKS - 1) * TICK_DIV) else $error("run dropped on short loss");
    a_restart_healthy: assert property ($rose(motor.soft_restart)
        |-> !phase_input_alarm && !plant.multi_loss) else $error("restart while faulted");
    a_trip_delay: assert property ($rose(phase_input_alarm)
        |-> loss_n >= (TRIP_TICKS - 1) * TICK_DIV) else $error("phase alarm early");
    a_link_delay: assert property ($rose(serial_link_alarm)
        |-> quiet_n >= (LINK_TICKS - 1) * TICK_DIV) else $error("link alarm early");
    a_link_react: assert property ($rose(serial_link_alarm) && link_react == LINK_STOP_ALARM
        |-> ##[0:2] !motor.run) else $error("link stop missing");
    a_link_clear: assert property ((serial_link_alarm && oper.link_activity) [*8]
        |=> !serial_link_alarm) else $error("link alarm kept");
    a_fw_option: assert property ($rose(motor.freewheel_stop) |-> single_phase_run)
        else $error("freewheel without option");
    a_cl_cause: assert property ($rose(current_limit_timeout_alarm) |-> plant.cl_mode)
        else $error("time-out alarm outside mode");
    a_cl_trip: assert property ($rose(current_limit_timeout_alarm) && !continue_on_timeout
        |-> ##[0:2] !motor.run) else $error("time-out trip missing");
    a_ramp_option: assert property ($rose(motor.full_ramp_6s)
        |-> continue_on_timeout && current_limit_timeout_alarm) else $error("ramp without option");
endmodule
bind motor_start_fault_supervisor fault_sup_props #(.TICK_DIV(TICK_DIV)) u_props (
    .sys_clk(sys_clk), .reset(reset), .single_phase_run(single_phase_run), .plant(plant),
    .continue_on_timeout(continue_on_timeout), .oper(oper), .link_react(link_react), .motor(motor),
    .phase_input_alarm(phase_input_alarm), .current_limit_timeout_alarm(current_limit_timeout_alarm),
    .serial_link_alarm(serial_link_alarm));

// File: verif/plant_model.sv
// Purpose: mains and ramp stand-in
// Assumes: ramp restarts whenever run drops
// Notes:   no mains noise modelled
module plant_model
    import fault_sup_pkg::*;
#(
    parameter int ACC = 60
) (
    input wire logic sys_clk, run, lim_off, multi, single, stuck, cl,
    output fault_sup_pkg::plant_t plant
);
    int n = 0;
    always_ff @(posedge sys_clk) n <= run ? (n < ACC ? n + 1 : n) : 0;
    always_comb begin
        plant.multi_loss       = multi;
        plant.single_loss      = single;
        plant.accelerating     = run && n < ACC;
        plant.full_voltage     = run && n == ACC;
        plant.current_limiting = stuck && run && !lim_off;
        plant.ramp_elapsed     = n == ACC;
        plant.cl_mode          = cl;
    end
endmodule

// File: verif/motor_start_fault_supervisor_tb.sv
// Purpose: self-checking bench for the fault supervisor
// Assumes: TICK_DIV 1, so 2 s is 2000 cycles
// Notes:   commands held 8 cycles to pass the input filter
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module motor_start_fault_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fault_sup_pkg::*;
    logic        sys_clk = 0, reset = 1, spr = 0, cot = 0, multi = 0, single = 0, stuck = 0, cl = 0;
    logic        pa, ta, la, sr_seen = 0, fw_seen = 0;
    link_react_t react = LINK_IGNORE;
    oper_t       oper = '0;
    plant_t      plant;
    motor_t      motor;
    int          n_fail = 0, n_compared = 0;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (motor.soft_restart === 1'b1) sr_seen <= 1;
        if (motor.freewheel_stop === 1'b1) fw_seen <= 1;
    end
    plant_model mdl (.sys_clk(sys_clk), .run(motor.run), .lim_off(motor.limit_release), .multi(multi),
        .single(single), .stuck(stuck), .cl(cl), .plant(plant));
    motor_start_fault_supervisor #(.TICK_DIV(1)) uut (.sys_clk(sys_clk), .reset(reset), .plant(plant),
        .oper(oper), .single_phase_run(spr), .continue_on_timeout(cot), .link_react(react), .motor(motor),
        .phase_input_alarm(pa), .current_limit_timeout_alarm(ta), .serial_link_alarm(la));
    function automatic logic exp_alarm(link_react_t r);
        return r != LINK_IGNORE;
    endfunction
    function automatic logic exp_run(link_react_t r);
        return r != LINK_STOP_ALARM;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Command 0 start, 1 stop, 2 keypad reset
    task automatic cmd(input int k);
        oper.start_cmd = k == 0;
        oper.stop_cmd = k == 1;
        oper.reset_key = k == 2;
        cyc(8);
        oper = oper & 5'b00011;
        cyc(8);
    endtask
    task automatic results;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h5315));
        cyc(12);
        reset = 0;
        cmd(0);
        multi = 1;
        cyc(5 + $urandom % 80);
        multi = 0;
        cyc(20);
        `CHK("short run", 1'b1, motor.run)
        `CHK("short restart", 1'b0, sr_seen)
        multi = 1;
        cyc(150 + $urandom % 1800);
        `CHK("pause run", 1'b0, motor.run)
        multi = 0;
        cyc(30);
        `CHK("restart", 1'b1, sr_seen)
        multi = 1;
        cyc(2100);
        `CHK("multi alarm", 1'b1, pa)
        multi = 0;
        cmd(0);
        `CHK("cat2 clear", 1'b0, pa)
        `CHK("cat2 run", 1'b1, motor.run)
        for (int s = 0; s < 2; s++) begin
            spr = s[0];
            cyc(80);
            single = 1;
            cyc(2100);
            `CHK("single alarm", 1'b1, pa)
            `CHK("single run", s[0], motor.run)
            if (s == 1) cmd(1);
            `CHK("freewheel", s[0], fw_seen)
            single = 0;
            cyc(20);
            `CHK("phase back", ~s[0], pa)
            cmd(0);
        end
        cl = 1;
        stuck = 1;
        for (int c = 0; c < 2; c++) begin
            cot = c[0];
            cmd(1);
            cmd(0);
            cyc(80);
            `CHK("time-out", 1'b1, ta)
            `CHK("time-out run", c[0], motor.run)
            `CHK("release", c[0], motor.limit_release)
            `CHK("ramp 6s", c[0], motor.full_ramp_6s)
            if (c == 1) cmd(2);
            `CHK("key clear", ~c[0], ta)
        end
        stuck = 0;
        oper.serial_mode = 1;
        for (int r = 0; r < 3; r++) begin
            react = link_react_t'(r);
            cmd(0);
            cyc(15100);
            `CHK("link alarm", exp_alarm(react), la)
            `CHK("link run", exp_run(react), motor.run)
            if (r == 2) cmd(2);
            oper.link_activity = r != 2;
            cyc(10);
            `CHK("link clear", 1'b0, la)
            oper.link_activity = 0;
        end
        results();
    end
    // Tests take about 55k cycles
    initial begin
        cyc(80000);
        n_fail++;
        results();
    end
endmodule
